// *** rsarb_pkg.sv ***
// Package: reset source arbiter constants, register map and types
package rsarb_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  RSARB_OFS_COMMAND = 8'h00;
    localparam logic [7:0]  RSARB_OFS_STATUS  = 8'h04;
    localparam logic [7:0]  RSARB_OFS_MODE    = 8'h08;
    localparam logic [7:0]  RSARB_PASSWORD    = 8'hA5;
    localparam int          RSARB_KEY_LSB     = 24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          RSARB_CMD_CPU     = 0;
    localparam int          RSARB_CMD_PERIPH  = 2;
    localparam int          RSARB_CMD_PIN     = 3;
    localparam int          RSARB_ST_EDGE     = 0;
    localparam int          RSARB_ST_CAUSE    = 8;
    localparam int          RSARB_ST_LEVEL    = 16;
    localparam int          RSARB_ST_BUSY     = 17;
    localparam int          RSARB_MD_UREN     = 0;
    localparam int          RSARB_MD_IRQEN    = 4;
    localparam int          RSARB_MD_LEN      = 8;
    localparam logic [31:0] RSARB_MODE_RESET  = 32'h0000_0001;

    // ------------------------------------------------------------------
    // Reset causes and timing
    // ------------------------------------------------------------------
    localparam logic [2:0]  RSARB_CAUSE_GEN   = 3'h0;
    localparam logic [2:0]  RSARB_CAUSE_BKP   = 3'h1;
    localparam logic [2:0]  RSARB_CAUSE_WDT   = 3'h2;
    localparam logic [2:0]  RSARB_CAUSE_SW    = 3'h3;
    localparam logic [2:0]  RSARB_CAUSE_USER  = 3'h4;
    localparam logic [1:0]  RSARB_HOLD_SLOW   = 2'h3;
    localparam logic [15:0] RSARB_SLOW_DIV    = 16'h0131;

    typedef enum logic [2:0] {
        RSARB_IDLE,
        RSARB_GENERAL,
        RSARB_BACKUP,
        RSARB_WATCHDOG,
        RSARB_SOFTWARE,
        RSARB_USER
    } rsarb_state_e;

endpackage : rsarb_pkg

// *** rsarb_pin_if.sv ***
// Interface: request and status between state manager and pin shaper
`timescale 1ns/10ps
interface rsarb_pin_if;
    logic       start;
    logic [3:0] length;
    logic       busy;
    modport mgr (output start, output length, input busy);
    modport pin (input start, input length, output busy);
endinterface : rsarb_pin_if

// *** rsarb_pin_shaper.sv ***
// Pin shaper: drives the reset pin low for 2^(len+1) slow cycles
`timescale 1ns/10ps
module rsarb_pin_shaper
    import rsarb_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  reset_i,
    input  wire logic  slow_tick_i,
    rsarb_pin_if.pin   req,
    output logic       pin_drive_low_o
);
    logic [16:0] count_q;
    logic        active_q;

    // Power-up pulse: starts active with the default length
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            active_q <= 1'b1;
            count_q  <= 17'h00002;
        end else if (req.start && !active_q) begin
            active_q <= 1'b1;
            count_q  <= 17'h00001 << (5'(req.length) + 5'h01);
        end else if (active_q && slow_tick_i) begin
            if (count_q <= 17'h00001) begin
                active_q <= 1'b0;
            end
            count_q <= count_q - 17'h00001;
        end
    end

    assign req.busy        = active_q;
    assign pin_drive_low_o = active_q;
endmodule : rsarb_pin_shaper

// *** reset_source_arbiter_regs.sv ***
// Top: reset source arbitration, cause recording and AHB-Lite registers
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module reset_source_arbiter_regs
    import rsarb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        general_reset_i,
    input  wire logic        backup_reset_i,
    input  wire logic        watchdog_fault_i,
    input  wire logic        pin_i,
    output logic             pin_o,
    output logic             pin_oe_n_o,
    output logic             cpu_reset_o,
    output logic             periph_reset_o,
    output logic             irq_o
);
    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic        rd_now;
    logic        take;
    logic        key_ok;
    logic        cmd_wr;
    logic        mode_wr;
    logic [31:0] mode_q;
    logic [31:0] status;
    logic [31:0] rdata_q;
    logic        status_rd;

    assign take        = hsel_i && hready_i && htrans_i[1];
    assign rd_now      = take && !hwrite_i;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = rdata_q;
    assign status_rd   = rd_now && haddr_i[7:0] == RSARB_OFS_STATUS;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite_i;
            wr_addr_q <= haddr_i[7:0];
        end
    end

    // Unmapped addresses read zero, writes dropped
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_now) begin
            case (haddr_i[7:0])
                RSARB_OFS_STATUS: rdata_q <= status;
                RSARB_OFS_MODE:   rdata_q <= mode_q;
                default:          rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign key_ok  = hwdata_i[31:RSARB_KEY_LSB] == RSARB_PASSWORD;
    assign cmd_wr  = wr_pend_q && key_ok
                     && wr_addr_q == RSARB_OFS_COMMAND;
    assign mode_wr = wr_pend_q && key_ok && wr_addr_q == RSARB_OFS_MODE;

    // Key byte reads back as zero; only used bits kept
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= RSARB_MODE_RESET;
        end else if (mode_wr) begin
            mode_q <= hwdata_i & 32'h0000_0F11;
        end
    end

    // ------------------------------------------------------------------
    // Slow clock enable
    // ------------------------------------------------------------------
    logic [15:0] div_q;
    logic        slow_tick;

    assign slow_tick = div_q == 16'h0000;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q <= RSARB_SLOW_DIV;
        end else if (slow_tick) begin
            div_q <= RSARB_SLOW_DIV;
        end else begin
            div_q <= div_q - 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    logic pin_q;
    logic pin_prev_q;
    logic edge_q;
    logic fall;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_q      <= 1'b1;
            pin_prev_q <= 1'b1;
        end else begin
            pin_q      <= pin_i;
            pin_prev_q <= pin_q;
        end
    end

    assign fall = pin_prev_q && !pin_q;

    // Set wins over a clearing read in the same cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            edge_q <= 1'b0;
        end else if (fall) begin
            edge_q <= 1'b1;
        end else if (status_rd) begin
            edge_q <= 1'b0;
        end
    end

    assign irq_o = edge_q && mode_q[RSARB_MD_IRQEN] && !mode_q[RSARB_MD_UREN];

    // ------------------------------------------------------------------
    // Reset state manager
    // ------------------------------------------------------------------
    rsarb_state_e state_q;
    logic [1:0]   hold_q;
    logic         sw_cpu_q;
    logic         sw_per_q;
    logic [2:0]   cause_q;
    logic [2:0]   pend_cause_q;
    logic         pin_start;
    logic         user_req;
    logic         sw_req;
    logic         busy;
    logic         shaper_busy;
    logic         shaper_busy_q;
    logic         wdt_enter;
    logic         sw_pin_start;

    rsarb_pin_if pin_bus ();

    // Sampled pin lags one clock behind the end of our own pulse
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            shaper_busy_q <= 1'b1;
        end else begin
            shaper_busy_q <= shaper_busy;
        end
    end

    // Pin held low by our own pulse never counts as user reset
    assign user_req = !pin_q && mode_q[RSARB_MD_UREN]
                      && !shaper_busy && !shaper_busy_q;
    assign busy     = state_q == RSARB_SOFTWARE;
    assign sw_req   = cmd_wr && !busy
                      && (hwdata_i[RSARB_CMD_CPU] || hwdata_i[RSARB_CMD_PERIPH]
                          || hwdata_i[RSARB_CMD_PIN]);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q  <= RSARB_GENERAL;
            hold_q   <= RSARB_HOLD_SLOW;
            sw_cpu_q <= 1'b0;
            sw_per_q <= 1'b0;
        end else if (general_reset_i) begin
            state_q <= RSARB_GENERAL;
            hold_q  <= RSARB_HOLD_SLOW;
        end else if (backup_reset_i) begin
            state_q <= RSARB_BACKUP;
            hold_q  <= RSARB_HOLD_SLOW;
        end else begin
            case (state_q)
                RSARB_IDLE: begin
                    if (watchdog_fault_i) begin
                        state_q <= RSARB_WATCHDOG;
                        hold_q  <= RSARB_HOLD_SLOW;
                    end else if (sw_req) begin
                        state_q  <= RSARB_SOFTWARE;
                        hold_q   <= RSARB_HOLD_SLOW;
                        sw_cpu_q <= hwdata_i[RSARB_CMD_CPU];
                        sw_per_q <= hwdata_i[RSARB_CMD_PERIPH];
                    end else if (user_req) begin
                        state_q <= RSARB_USER;
                    end
                end
                RSARB_SOFTWARE: begin
                    if (watchdog_fault_i) begin
                        state_q <= RSARB_WATCHDOG;
                        hold_q  <= RSARB_HOLD_SLOW;
                    end else if (slow_tick) begin
                        if (hold_q == 2'h1) begin
                            state_q <= RSARB_IDLE;
                        end
                        hold_q <= hold_q - 2'h1;
                    end
                end
                RSARB_USER: begin
                    // Watchdog and commands ignored here
                    if (pin_q && !shaper_busy) begin
                        state_q <= RSARB_IDLE;
                    end
                end
                RSARB_GENERAL, RSARB_BACKUP, RSARB_WATCHDOG: begin
                    // Software and pin ignored while held
                    if (slow_tick) begin
                        if (hold_q == 2'h1) begin
                            state_q <= RSARB_IDLE;
                        end
                        hold_q <= hold_q - 2'h1;
                    end
                end
                default: state_q <= RSARB_IDLE;
            endcase
        end
    end

    // Cause of the reset currently in progress
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pend_cause_q <= RSARB_CAUSE_GEN;
        end else begin
            case (state_q)
                RSARB_GENERAL:  pend_cause_q <= RSARB_CAUSE_GEN;
                RSARB_BACKUP:   pend_cause_q <= RSARB_CAUSE_BKP;
                RSARB_WATCHDOG: pend_cause_q <= RSARB_CAUSE_WDT;
                RSARB_SOFTWARE: pend_cause_q <= RSARB_CAUSE_SW;
                RSARB_USER:     pend_cause_q <= RSARB_CAUSE_USER;
                default:        pend_cause_q <= pend_cause_q;
            endcase
        end
    end

    always_comb begin
        case (state_q)
            RSARB_SOFTWARE: cpu_reset_o = sw_cpu_q;
            RSARB_IDLE:     cpu_reset_o = 1'b0;
            default:        cpu_reset_o = 1'b1;
        endcase
    end

    always_comb begin
        case (state_q)
            RSARB_SOFTWARE: periph_reset_o = sw_per_q;
            RSARB_IDLE:     periph_reset_o = 1'b0;
            default:        periph_reset_o = 1'b1;
        endcase
    end

    // Only resets that touched the cpu are recorded, at release
    logic cpu_prev_q;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cpu_prev_q <= 1'b1;
            cause_q    <= RSARB_CAUSE_GEN;
        end else begin
            cpu_prev_q <= cpu_reset_o;
            if (cpu_prev_q && !cpu_reset_o) begin
                cause_q <= pend_cause_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin shaper
    // ------------------------------------------------------------------
    // One start per entry; a level would restart a short pulse
    assign wdt_enter    = watchdog_fault_i && !general_reset_i
                          && !backup_reset_i
                          && (state_q == RSARB_IDLE
                              || state_q == RSARB_SOFTWARE);
    assign sw_pin_start = sw_req && state_q == RSARB_IDLE
                          && !watchdog_fault_i && !general_reset_i
                          && !backup_reset_i && hwdata_i[RSARB_CMD_PIN];
    assign pin_start    = sw_pin_start || wdt_enter;
    assign pin_bus.start  = pin_start;
    assign pin_bus.length = mode_q[RSARB_MD_LEN +: 4];
    assign shaper_busy    = pin_bus.busy;

    logic drive_low;

    rsarb_pin_shaper u_shaper (
        .clk_i           (clk_i),
        .reset_i         (reset_i),
        .slow_tick_i     (slow_tick),
        .req             (pin_bus.pin),
        .pin_drive_low_o (drive_low)
    );

    assign pin_o      = 1'b0;
    assign pin_oe_n_o = !drive_low;

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    always_comb begin
        status                          = 32'h0000_0000;
        status[RSARB_ST_EDGE]           = edge_q;
        status[RSARB_ST_CAUSE +: 3]     = cause_q;
        status[RSARB_ST_LEVEL]          = pin_q;
        status[RSARB_ST_BUSY]           = busy;
    end

endmodule : reset_source_arbiter_regs

// *** rsarb_assertions.sv ***
// Checker: port-level properties of the reset source arbiter
`timescale 1ns/10ps
module rsarb_assertions (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic        general_reset_i,
    input  wire logic        backup_reset_i,
    input  wire logic        watchdog_fault_i,
    input  wire logic        pin_i,
    input  wire logic        pin_oe_n_o,
    input  wire logic        cpu_reset_o,
    input  wire logic        periph_reset_o,
    input  wire logic        irq_o
);
    import rsarb_pkg::*;
    localparam int MIN_LOW = 306;
    logic        take;
    logic        key_ok;
    logic        cmd_ok;
    logic        quiet;
    logic        dp_wr_q;
    logic [7:0]  dp_adr_q;
    logic [31:0] mode_q;
    logic [15:0] low_q;
    assign take   = hsel_i && hready_i && htrans_i[1];
    assign key_ok = hwdata_i[31:24] == RSARB_PASSWORD;
    // Only with peripherals out of reset and pin released: a busy controller may ignore commands
    assign cmd_ok = dp_wr_q && dp_adr_q == RSARB_OFS_COMMAND && key_ok
                    && !periph_reset_o && pin_oe_n_o;
    assign quiet  = !cpu_reset_o && pin_oe_n_o && pin_i && !general_reset_i
                    && !backup_reset_i && !watchdog_fault_i;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dp_wr_q  <= 1'b0;
            dp_adr_q <= 8'h00;
            mode_q   <= RSARB_MODE_RESET;
            low_q    <= 16'h0000;
        end else begin
            dp_wr_q  <= take && hwrite_i;
            dp_adr_q <= haddr_i[7:0];
            if (dp_wr_q && dp_adr_q == RSARB_OFS_MODE && key_ok) begin
                mode_q <= hwdata_i;
            end
            low_q    <= pin_oe_n_o ? 16'h0000 : low_q + 16'h0001;
        end
    end
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_hi_src;
        (general_reset_i || backup_reset_i) |=> cpu_reset_o;
    endproperty
    property p_wdt;
        watchdog_fault_i |-> ##[1:2] cpu_reset_o;
    endproperty
    property p_cpu_cmd;
        cmd_ok && hwdata_i[RSARB_CMD_CPU] |-> ##[1:2] cpu_reset_o;
    endproperty
    property p_pin_cmd;
        cmd_ok && hwdata_i[RSARB_CMD_PIN] |-> ##[1:3] !pin_oe_n_o;
    endproperty
    property p_bad_key;
        dp_wr_q && dp_adr_q == RSARB_OFS_COMMAND && !key_ok && quiet
            |=> !cpu_reset_o && pin_oe_n_o;
    endproperty
    property p_pin_len;
        $rose(pin_oe_n_o) |-> low_q >= MIN_LOW;
    endproperty
    property p_edge_irq;
        $fell(pin_i) && mode_q[RSARB_MD_IRQEN] && !mode_q[RSARB_MD_UREN]
            |-> ##[1:3] irq_o;
    endproperty
    property p_irq_gate;
        irq_o |-> mode_q[RSARB_MD_IRQEN] && !mode_q[RSARB_MD_UREN];
    endproperty
    property p_rd_clr;
        take && !hwrite_i && haddr_i[7:0] == RSARB_OFS_STATUS && pin_i
            && $past(pin_i) && $past(pin_i, 2) ##1 pin_i |-> ##1 !irq_o;
    endproperty
    a_hi_src: assert property (p_hi_src)
        else $error("high source did not reset cpu");
    a_wdt: assert property (p_wdt)
        else $error("watchdog fault did not reset cpu");
    a_cpu_cmd: assert property (p_cpu_cmd)
        else $error("cpu command did not reset cpu");
    a_pin_cmd: assert property (p_pin_cmd)
        else $error("pin command did not drive pin");
    a_bad_key: assert property (p_bad_key)
        else $error("bad key command took effect");
    a_pin_len: assert property (p_pin_len)
        else $error("pin pulse too short");
    a_edge_irq: assert property (p_edge_irq)
        else $error("pin fall raised no interrupt");
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt while not enabled");
    a_rd_clr: assert property (p_rd_clr)
        else $error("status read left interrupt set");
    c_cpu_cmd: cover property (cmd_ok && hwdata_i[RSARB_CMD_CPU]);
    c_irq: cover property ($rose(irq_o));
    c_pin: cover property ($rose(pin_oe_n_o));
endmodule // rsarb_assertions

// *** rsarb_ext_dev.sv ***
// Model: external device sharing the pulled-up reset line
`timescale 1ns/10ps
module rsarb_ext_dev (
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic [11:0] len_i,
    input  wire logic        dev_pin_i,
    input  wire logic        dev_oe_n_i,
    output logic             line_o
);
    logic [11:0] cnt_q = 12'h000;
    always_ff @(posedge clk_i) begin
        if (start_i) begin
            cnt_q <= len_i;
        end else if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
        end
    end
    // Pull-up: line low whenever either party pulls it
    assign line_o = !(cnt_q != 12'h000 || (!dev_oe_n_i && !dev_pin_i));
endmodule // rsarb_ext_dev

// *** tb_top.sv ***
// Testbench: register, reset source and reset pin scenarios
`timescale 1ns/10ps
module tb_top;
    import rsarb_pkg::*;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        hsel_i = 1'b0;
    logic        hwrite_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic [2:0]  src_q = 3'h0;
    logic        ext_go = 1'b0;
    logic [11:0] ext_len = 12'h000;
    logic [31:0] hrdata_o, rd, d, mode;
    logic [31:0] lfsr = 32'h19;
    logic        hreadyout_o, hresp_o, pin_i, pin_o, pin_oe_n_o;
    logic        cpu_reset_o, periph_reset_o, irq_o, len;
    int          failures = 0;
    int          checks_done = 0;
    int          pin_cnt = 0;
    int          cpu_cnt = 0;
    int          n, ticks;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        pin_cnt += int'(!pin_oe_n_o);
        cpu_cnt += int'(cpu_reset_o);
    end
    reset_source_arbiter_regs i_reset_source_arbiter_regs (
        .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .general_reset_i(src_q[2]), .backup_reset_i(src_q[1]),
        .watchdog_fault_i(src_q[0]), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n_o), .cpu_reset_o(cpu_reset_o),
        .periph_reset_o(periph_reset_o), .irq_o(irq_o));
    rsarb_ext_dev i_rsarb_ext_dev (.clk_i(clk_i), .start_i(ext_go),
        .len_i(ext_len), .dev_pin_i(pin_o), .dev_oe_n_i(pin_oe_n_o),
        .line_o(pin_i));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic stop();
        failures++;
        test_done();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic hold_rdy();
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (hreadyout_o === 1'b1)
                break;
        end
        if (n == 50)
            stop();
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {24'h0, a};
        hold_rdy();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= v;
        hold_rdy();
        rd = hrdata_o;
    endtask
    task automatic st(input logic e, input logic [2:0] c, input logic l,
                      input logic b);
        bus(1'b0, RSARB_OFS_STATUS, 32'h0);
        chk(rd, {14'h0, b, l, 5'h0, c, 7'h0, e});
    endtask
    // Edge flag left out where the pin's own pulse is not guaranteed
    task automatic stc(input logic [2:0] c);
        bus(1'b0, RSARB_OFS_STATUS, 32'h0);
        chk(rd & 32'hFFFF_FFFE, {15'h0, 1'b1, 5'h0, c, 8'h0});
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_i);
        for (n = 0; n < 40000; n++) begin
            if (pin_i && pin_oe_n_o && !cpu_reset_o && !periph_reset_o)
                break;
            @(posedge clk_i);
        end
        if (n == 40000)
            stop();
        repeat (3) @(posedge clk_i);
    endtask
    task automatic src(input logic [2:0] m);
        src_q <= m;
        @(posedge clk_i);
        src_q <= 3'h0;
        settle();
    endtask
    task automatic ext(input logic [11:0] l);
        ext_len <= l;
        ext_go <= 1'b1;
        @(posedge clk_i);
        ext_go <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        settle();
        bus(1'b0, RSARB_OFS_MODE, 32'h0);
        chk(rd, RSARB_MODE_RESET);
        stc(RSARB_CAUSE_GEN);
        st(1'b0, RSARB_CAUSE_GEN, 1'b1, 1'b0);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, RSARB_OFS_COMMAND, 32'h5A00_0001);
        repeat (4) @(posedge clk_i);
        chk(32'(cpu_reset_o), 32'h0);
        mode = RSARB_MODE_RESET;
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt(lfsr);
            d = lfsr & 32'hFFFF_FFFE;
            if (i[0])
                d[31:24] = RSARB_PASSWORD;
            bus(1'b1, RSARB_OFS_MODE, d);
            if (d[31:24] == RSARB_PASSWORD)
                mode = d & 32'h0000_0F11;
            bus(1'b0, RSARB_OFS_MODE, 32'h0);
            chk(rd, mode);
        end
        len = lfsr[8];
        bus(1'b1, RSARB_OFS_MODE, {24'hA5_0000 | 24'(len), 8'h10});
        cpu_cnt = 0;
        ext(12'd40);
        repeat (10) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        st(1'b1, RSARB_CAUSE_GEN, 1'b0, 1'b0);
        @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        repeat (40) @(posedge clk_i);
        st(1'b0, RSARB_CAUSE_GEN, 1'b1, 1'b0);
        bus(1'b1, RSARB_OFS_MODE, {24'hA5_0000 | 24'(len), 8'h00});
        ext(12'd20);
        repeat (30) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        bus(1'b1, RSARB_OFS_MODE, {24'hA5_0000 | 24'(len), 8'h10});
        @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        st(1'b1, RSARB_CAUSE_GEN, 1'b1, 1'b0);
        chk(cpu_cnt, 32'h0);
        pin_cnt = 0;
        cpu_cnt = 0;
        bus(1'b1, RSARB_OFS_COMMAND, 32'hA500_000D);
        repeat (6) @(posedge clk_i);
        chk(32'({cpu_reset_o, periph_reset_o, pin_oe_n_o}), 32'h6);
        st(1'b1, RSARB_CAUSE_GEN, 1'b0, 1'b1);
        settle();
        ticks = 2 << len;
        chk(32'(cpu_cnt >= 612 && cpu_cnt <= 924), 32'h1);
        chk(32'(pin_cnt >= (ticks - 1) * 306 && pin_cnt <= ticks * 306 + 4),
            32'h1);
        st(1'b0, RSARB_CAUSE_SW, 1'b1, 1'b0);
        bus(1'b1, RSARB_OFS_COMMAND, 32'hA500_0001);
        repeat (100) @(posedge clk_i);
        src(3'h1);
        st(1'b1, RSARB_CAUSE_WDT, 1'b1, 1'b0);
        cpu_cnt = 0;
        bus(1'b1, RSARB_OFS_COMMAND, 32'hA500_0004);
        bus(1'b1, RSARB_OFS_COMMAND, 32'hA500_0001);
        settle();
        chk(cpu_cnt, 32'h0);
        stc(RSARB_CAUSE_WDT);
        src(3'h3);
        stc(RSARB_CAUSE_BKP);
        src(3'h4);
        stc(RSARB_CAUSE_GEN);
        cpu_cnt = 0;
        src(3'h1);
        chk(32'(cpu_cnt >= 612 && cpu_cnt <= 924), 32'h1);
        bus(1'b1, RSARB_OFS_MODE, 32'hA500_0001);
        cpu_cnt = 0;
        ext(12'd1000);
        repeat (900) @(posedge clk_i);
        src(3'h1);
        chk(32'(cpu_cnt > 0), 32'h1);
        stc(RSARB_CAUSE_USER);
        test_done();
    end
endmodule // tb_top
bind reset_source_arbiter_regs rsarb_assertions i_rsarb_assertions (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .general_reset_i(general_reset_i),
    .backup_reset_i(backup_reset_i), .watchdog_fault_i(watchdog_fault_i),
    .pin_i(pin_i), .pin_oe_n_o(pin_oe_n_o), .cpu_reset_o(cpu_reset_o),
    .periph_reset_o(periph_reset_o), .irq_o(irq_o));
